// ===== design/e1_alarm_detect.sv
// line alarm detectors working one line bit at a time
`timescale 1ns/1ps
`include "e1_rx_alarm_regs.svh"
module e1_alarm_detect (
    input  wire logic                           mclk,
    input  wire logic                           nrst,
    input  wire logic                           bit_strobe,
    input  wire logic                           mark,
    input  wire e1_rx_alarm_pkg::line_pos_type  pos,
    input  wire logic                           ua1_restart,
    output e1_rx_alarm_pkg::alarm_level_type    level
);
    logic       ts16;
    logic       mf_end;
    logic [1:0] sa_zero_cnt;
    logic [1:0] next_sa_zero;
    logic       sa_one_seen;
    logic       dma_last;
    logic       rra_last;
    logic [1:0] rra_run;
    logic [1:0] next_rra_run;
    logic [8:0] ua1_bit_cnt;
    logic [1:0] ua1_zero_cnt;
    logic [1:0] next_ua1_zero;
    logic [7:0] rcl_zero_run;
    logic [7:0] rcl_win_cnt;
    logic [5:0] rcl_ones;

    // position decode taken from the synchronizer
    assign ts16   = pos.timeslot == `TS_SIGNALING;
    assign mf_end = pos.frame == `FRAME_LAST && pos.timeslot == `TS_LAST
                    && pos.bit_no == `BIT_LAST;
    assign next_sa_zero = (ts16 && !mark && sa_zero_cnt != 2'h3)
                          ? sa_zero_cnt + 2'h1 : sa_zero_cnt;
    assign next_rra_run = (mark != rra_last) ? 2'h1
                          : (rra_run == 2'h3) ? rra_run : rra_run + 2'h1;
    assign next_ua1_zero = (!mark && ua1_zero_cnt != 2'h3)
                           ? ua1_zero_cnt + 2'h1 : ua1_zero_cnt;

    // ts16 zero/one census per multiframe, judged at its last bit
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sa_zero_cnt <= 2'h0;
            sa_one_seen <= 1'b0;
            level.sa1   <= 1'b0;
            level.sa0   <= 1'b0;
        end else if (bit_strobe) begin
            if (mf_end) begin
                level.sa1   <= next_sa_zero < `SA1_ZERO_MIN;
                level.sa0   <= !sa_one_seen;
                sa_zero_cnt <= 2'h0;
                sa_one_seen <= 1'b0;
            end else begin
                sa_zero_cnt <= next_sa_zero;
                sa_one_seen <= sa_one_seen | (ts16 & mark);
            end
        end
    end

    // frame 0 ts16 bit 6, two equal multiframes move the alarm
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dma_last  <= 1'b0;
            level.dma <= 1'b0;
        end else if (bit_strobe && ts16 && pos.frame == 4'h0
                     && pos.bit_no == `BIT_SIX) begin
            if (mark == dma_last)
                level.dma <= mark;
            dma_last <= mark;
        end
    end

    // bit 3 of timeslot 0 in odd (non-align) frames
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rra_last  <= 1'b0;
            rra_run   <= 2'h0;
            level.remote_alarm_flag <= 1'b0;
        end else if (bit_strobe && pos.frame[0]
                     && pos.timeslot == `TS_ALIGN
                     && pos.bit_no == `BIT_THREE) begin
            rra_last <= mark;
            rra_run  <= next_rra_run;
            if (next_rra_run == `RRA_RUN)
                level.remote_alarm_flag <= mark;
        end
    end

    // free 512 bit windows, restarted by a clearing write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ua1_bit_cnt  <= 9'h000;
            ua1_zero_cnt <= 2'h0;
            level.ua1    <= 1'b0;
        end else if (ua1_restart) begin
            ua1_bit_cnt  <= 9'h000;
            ua1_zero_cnt <= 2'h0;
            level.ua1    <= 1'b0;
        end else if (bit_strobe) begin
            if (ua1_bit_cnt == `UA1_WINDOW_END) begin
                level.ua1    <= next_ua1_zero < `UA1_ZERO_MIN;
                ua1_bit_cnt  <= 9'h000;
                ua1_zero_cnt <= 2'h0;
            end else begin
                ua1_bit_cnt  <= ua1_bit_cnt + 9'h001;
                ua1_zero_cnt <= next_ua1_zero;
            end
        end
    end

    // zero run sets; while set, 255 bit windows count ones to clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rcl_zero_run <= 8'h00;
            rcl_win_cnt  <= 8'h00;
            rcl_ones     <= 6'h00;
            level.carrier_loss_alarm    <= 1'b0;
        end else if (bit_strobe) begin
            rcl_zero_run <= mark ? 8'h00
                            : (rcl_zero_run == `RCL_ZERO_RUN) ? rcl_zero_run
                            : rcl_zero_run + 8'h01;
            if (!level.carrier_loss_alarm) begin
                rcl_win_cnt <= 8'h00;
                rcl_ones    <= 6'h00;
                if (!mark && rcl_zero_run == `RCL_ZERO_RUN - 8'h01)
                    level.carrier_loss_alarm <= 1'b1;
            end else if (rcl_win_cnt == `RCL_WINDOW_END) begin
                // judged on the 255th bit including this one
                if (rcl_ones + {5'h00, mark} >= `RCL_ONES_MIN)
                    level.carrier_loss_alarm <= 1'b0;
                rcl_win_cnt <= 8'h00;
                rcl_ones    <= 6'h00;
            end else begin
                rcl_win_cnt <= rcl_win_cnt + 8'h01;
                if (mark && rcl_ones != `RCL_ONES_MIN)
                    rcl_ones <= rcl_ones + 6'h01;
            end
        end
    end
endmodule

// ===== design/e1_receive_alarm_status.sv
// e1 receive alarm, information and synchronizer status registers
`timescale 1ns/1ps
`include "e1_rx_alarm_regs.svh"
module e1_receive_alarm_status (
    input  wire logic                             mclk,
    input  wire logic                             nrst,
    input  wire logic                             rclk,
    input  wire logic                             rx_positive_rail,
    input  wire logic                             rx_negative_rail,
    input  wire logic                             tclk,
    input  wire logic                             tx_positive_rail,
    input  wire logic                             tx_negative_rail,
    input  wire logic                             cs_n,
    input  wire logic                             rd_n,
    input  wire logic                             wr_n,
    input  wire logic                             ale,
    input  wire logic [7:0]                       ad_in,
    output logic      [7:0]                       ad_out,
    output logic                                  ad_oe_n,
    input  wire e1_rx_alarm_pkg::line_pos_type    pos,
    input  wire e1_rx_alarm_pkg::sync_status_type sync,
    output logic                                  line_bit_strobe,
    output logic                                  line_mark,
    output logic      [7:0]                       common_control,
    output logic                                  first_irq_out_n
);
    localparam int PIN_COUNT = 18;

    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic [PIN_COUNT-1:0] pin_last;
    logic       s_rclk;
    logic       s_rx_positive_rail;
    logic       s_rx_negative_rail;
    logic       s_tclk;
    logic       s_tpos;
    logic       s_tneg;
    logic       s_cs_n;
    logic [7:0] s_ad;
    logic       line_clk_rise;
    logic       ale_fall;
    logic       wr_rise;
    logic       rd_fall;
    logic       rd_rise;
    logic       wr_take;
    logic       rd_take;
    logic [7:0] addr;
    logic [7:0] first_irq_mask;
    logic [7:0] alarm_latch;
    logic [7:0] alarm_shadow;
    logic [7:0] alarm_set;
    logic [7:0] alarm_clr;
    logic [4:0] info_latch;
    logic [4:0] info_shadow;
    logic [4:0] info_set;
    logic [4:0] info_clr;
    logic [1:0] fas_err_run;
    logic [1:0] cas_err_run;
    logic [1:0] next_fas_run;
    logic [1:0] next_cas_run;
    logic [5:0] sync_search_cnt;
    logic [7:0] sync_state_live;
    logic [7:0] read_value;
    logic       ua1_restart;
    e1_rx_alarm_pkg::alarm_level_type level;

    // every pin crosses two flops before any logic reads it
    assign pin_raw = {rclk, rx_positive_rail, rx_negative_rail, tclk,
                      tx_positive_rail, tx_negative_rail, cs_n, rd_n,
                      wr_n, ale, ad_in};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin_sync
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                    pin_last[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                    pin_last[gi] <= pin_sync[gi];
                end
            end
        end
    endgenerate

    assign s_rclk = pin_sync[17];
    assign s_rx_positive_rail = pin_sync[16];
    assign s_rx_negative_rail = pin_sync[15];
    assign s_tclk = pin_sync[14];
    assign s_tpos = pin_sync[13];
    assign s_tneg = pin_sync[12];
    assign s_cs_n = pin_sync[11];
    assign s_ad   = pin_sync[7:0];

    // loopback swaps in the transmit clock and rails
    assign line_clk_rise = common_control[`CCR_LLB]
                           ? (s_tclk & ~pin_last[14])
                           : (s_rclk & ~pin_last[17]);
    assign ale_fall = ~pin_sync[8] & pin_last[8];
    assign wr_rise  = pin_sync[9] & ~pin_last[9];
    assign rd_fall  = ~pin_sync[10] & pin_last[10];
    assign rd_rise  = pin_sync[10] & ~pin_last[10];
    assign wr_take  = wr_rise & ~s_cs_n;
    assign rd_take  = rd_fall & ~s_cs_n;

    // one strobe per line bit for the detectors and the synchronizer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            line_bit_strobe <= 1'b0;
            line_mark       <= 1'b0;
        end else begin
            line_bit_strobe <= line_clk_rise;
            if (line_clk_rise)
                line_mark <= common_control[`CCR_LLB]
                             ? (s_tpos | s_tneg) : (s_rx_positive_rail | s_rx_negative_rail);
        end
    end

    e1_alarm_detect u_detect (
        .mclk        (mclk),
        .nrst        (nrst),
        .bit_strobe  (line_bit_strobe),
        .mark        (line_mark),
        .pos         (pos),
        .ua1_restart (ua1_restart),
        .level       (level)
    );

    // multiplexed address captured as address latch enable falls
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            addr <= 8'h00;
        else if (ale_fall)
            addr <= s_ad;
    end

    // plain control registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            common_control <= `REG_RESET;
            first_irq_mask <= `REG_RESET;
        end else if (wr_take) begin
            if (addr == `ADDR_COMMON_CTRL)
                common_control <= s_ad;
            if (addr == `ADDR_IRQ_MASK)
                first_irq_mask <= s_ad;
        end
    end

    // a written one both refreshes the read copy and clears the latch
    assign alarm_clr   = (wr_take && addr == `ADDR_ALARM_STATUS)
                         ? s_ad : 8'h00;
    assign info_clr    = (wr_take && addr == `ADDR_RX_INFO)
                         ? {s_ad[4:3], 1'b0, s_ad[1:0]} : 5'h00;
    assign ua1_restart = alarm_clr[`ALM_UA1];

    // levels re-set at once; unframed ones waits out a fresh window
    always_comb begin
        alarm_set            = 8'h00;
        alarm_set[`ALM_SA1]  = level.sa1;
        alarm_set[`ALM_DMA]  = level.dma;
        alarm_set[`ALM_SA0]  = level.sa0;
        alarm_set[`ALM_SLIP] = sync.slip_full | sync.slip_empty;
        alarm_set[`ALM_UA1]  = level.ua1 & ~ua1_restart;
        alarm_set[`ALM_RRA]  = level.remote_alarm_flag;
        alarm_set[`ALM_RCL]  = level.carrier_loss_alarm;
        alarm_set[`ALM_LOS]  = ~sync.in_sync;
    end

    // set wins over a same-cycle clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            alarm_latch  <= `REG_RESET;
            alarm_shadow <= `REG_RESET;
        end else begin
            alarm_latch  <= (alarm_latch & ~alarm_clr) | alarm_set;
            alarm_shadow <= (alarm_shadow & ~alarm_clr)
                            | (alarm_latch & alarm_clr);
        end
    end

    // consecutive errored alignment words
    assign next_fas_run = !sync.fas_error ? 2'h0
                          : (fas_err_run == `FAS_ERR_RUN) ? fas_err_run
                          : fas_err_run + 2'h1;
    assign next_cas_run = !sync.cas_error ? 2'h0
                          : (cas_err_run == `CAS_ERR_RUN) ? cas_err_run
                          : cas_err_run + 2'h1;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fas_err_run <= 2'h0;
            cas_err_run <= 2'h0;
        end else begin
            if (sync.fas_word)
                fas_err_run <= next_fas_run;
            if (sync.cas_word)
                cas_err_run <= next_cas_run;
        end
    end

    // info events; bit order {full, empty, unused, fas, cas}
    always_comb begin
        info_set    = 5'h00;
        info_set[4] = sync.slip_full;
        info_set[3] = sync.slip_empty;
        info_set[1] = sync.fas_word
                      && next_fas_run == `FAS_ERR_RUN;
        info_set[0] = sync.cas_word
                      && next_cas_run == `CAS_ERR_RUN;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            info_latch  <= 5'h00;
            info_shadow <= 5'h00;
        end else begin
            info_latch  <= (info_latch & ~info_clr) | info_set;
            info_shadow <= (info_shadow & ~info_clr)
                           | (info_latch & info_clr);
        end
    end

    // search counter wraps rather than saturating
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            sync_search_cnt <= 6'h00;
        else if (!common_control[`CCR_RCRC4] || sync.crc_sync_ok)
            sync_search_cnt <= 6'h00;
        else if (sync.crc_timeout)
            sync_search_cnt <= sync_search_cnt + 6'h01;
    end

    // live view; counter bit 1 is not visible
    assign sync_state_live = {sync_search_cnt[5:2], sync_search_cnt[0],
                              sync.fas_search, sync.cas_search,
                              sync.crc_search};

    // unassigned info positions read zero
    always_comb begin
        unique case (addr)
            `ADDR_ALARM_STATUS: read_value = alarm_shadow;
            `ADDR_RX_INFO:      read_value = {3'h0, info_shadow};
            `ADDR_SYNC_STATE:   read_value = sync_state_live;
            `ADDR_COMMON_CTRL:  read_value = common_control;
            `ADDR_IRQ_MASK:     read_value = first_irq_mask;
            default:            read_value = 8'h00;
        endcase
    end

    // bus driven from read strobe fall until it rises or select drops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ad_out  <= 8'h00;
            ad_oe_n <= 1'b1;
        end else if (rd_take) begin
            ad_out  <= read_value;
            ad_oe_n <= 1'b0;
        end else if (rd_rise || s_cs_n) begin
            ad_oe_n <= 1'b1;
        end
    end

    // interrupt is active low; masked latched alarms only
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            first_irq_out_n <= 1'b1;
        else
            first_irq_out_n <= ~|(alarm_latch & first_irq_mask);
    end
endmodule

// ===== design/e1_rx_alarm_pkg.sv
// types shared by the e1 receive alarm and status logic
package e1_rx_alarm_pkg;

    // position of the current line bit as the synchronizer sees it
    typedef struct packed {
        logic [4:0] timeslot;
        logic [2:0] bit_no;
        logic [3:0] frame;
    } line_pos_type;

    // synchronizer and elastic store state; levels and one-cycle events
    typedef struct packed {
        logic in_sync;
        logic fas_search;
        logic cas_search;
        logic crc_search;
        logic crc_sync_ok;
        logic crc_timeout;
        logic fas_word;
        logic fas_error;
        logic cas_word;
        logic cas_error;
        logic slip_full;
        logic slip_empty;
    } sync_status_type;

    // live alarm conditions from the line detectors
    typedef struct packed {
        logic sa1;
        logic dma;
        logic sa0;
        logic ua1;
        logic remote_alarm_flag;
        logic carrier_loss_alarm;
    } alarm_level_type;

endpackage

// ===== design/e1_rx_alarm_regs.svh
// register offsets, field positions and detector counts for the e1 alarm block
// Overview of operation
// - elastic store overflow deleting a frame sets the full flag in info
// - elastic store underflow repeating a frame sets the empty flag in info
// - three errored frame alignment words in a row set frame resync flag
// - two errored signaling multiframe words in a row set its resync flag
// - unassigned info bits 7,6,5,2 carry no meaning; host ignores them
// - sync state bits 7..3 show search counter bits 5,4,3,2,0
// - frame search active bit follows synchronizer frame hunt
// - signaling multiframe search bit follows its hunt
// - crc multiframe search bit follows its hunt
// - search counter advances on every 8 ms crc search timeout
// - search counter clears on crc sync or while crc receive disabled
// - search counter wraps to zero past its maximum
// - signaling all ones: under three ts16 zeros per multiframe
// - signaling all zeros: ts16 all zero over a whole multiframe
// - distant multiframe alarm follows two equal frame 0 ts16 bit 6 values
// - unframed all ones: under three zeros in a 512 bit window
// - remote alarm follows three equal non-align bit 3 values
// - carrier loss after 255 zeros; clears on 32 ones in 255 bits
// - sync lost alarm whenever receiver is not synchronized
// - slip flag sets when the elastic store repeats or drops a frame
// - alarm bits re-set after clearing if present; unframed ones re-evaluates
// - host writes mask, reads, then writes read value and mask back
// - sync state register is live, read only, needs no mask write
// - each latched alarm bit may drive the first interrupt, per mask
`ifndef E1_RX_ALARM_REGS_SVH
`define E1_RX_ALARM_REGS_SVH

`define ADDR_ALARM_STATUS  8'h06
`define ADDR_RX_INFO       8'h08
`define ADDR_SYNC_STATE    8'h09
`define ADDR_COMMON_CTRL   8'h14
`define ADDR_IRQ_MASK      8'h16

`define ALM_SA1   7
`define ALM_DMA   6
`define ALM_SA0   5
`define ALM_SLIP  4
`define ALM_UA1   3
`define ALM_RRA   2
`define ALM_RCL   1
`define ALM_LOS   0

`define INFO_ESF    4
`define INFO_ESE    3
`define INFO_FRAME_RESYNC_CRITERIA  1
`define INFO_SIG_MF_RESYNC_CRITERIA  0

`define CCR_LLB    7
`define CCR_RCRC4  0

`define REG_RESET       8'h00
`define FAS_ERR_RUN     2'h3
`define CAS_ERR_RUN     2'h2
`define SA1_ZERO_MIN    2'h3
`define UA1_ZERO_MIN    2'h3
`define UA1_WINDOW_END  9'h1FF
`define RRA_RUN         2'h3
`define RCL_ZERO_RUN    8'hFF
`define RCL_WINDOW_END  8'hFE
`define RCL_ONES_MIN    6'h20
`define TS_SIGNALING    5'h10
`define TS_ALIGN        5'h00
`define TS_LAST         5'h1F
`define FRAME_LAST      4'hF
`define BIT_LAST        3'h7
`define BIT_SIX         3'h5
`define BIT_THREE       3'h2

`endif

// ===== tb/e1_line_source.sv
// far-end line source: six mclk per bit, ami marks on alternate rails
`timescale 1ns/1ps
module e1_line_source (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic mark_in,
    output logic      rclk,
    output logic      rail_p,
    output logic      rail_n
);
    logic [2:0] phase;
    logic       polarity;
    // clock held low in reset so no false first edge is seen
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase <= 3'h0;
            rclk <= 1'b0;
        end else begin
            phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
            rclk <= (phase >= 3'h2 && phase <= 3'h4);
        end
    end
    // rails move as the clock falls, so they are steady at the rise
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {rail_p, rail_n, polarity} <= 3'h0;
        end else if (phase == 3'h5) begin
            rail_p <= mark_in & ~polarity;
            rail_n <= mark_in & polarity;
            polarity <= polarity ^ mark_in;
        end
    end
endmodule

// ===== tb/e1_rx_alarm_checker.sv
// port assertions for the e1 receive alarm and status block
`timescale 1ns/1ps
module e1_rx_alarm_checker (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       rclk,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       ad_oe_n,
    input wire logic       line_bit_strobe,
    input wire logic       line_mark,
    input wire logic [7:0] common_control
);
    logic [3:0] since_wr;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // cycles since the write strobe was last low, saturating
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) since_wr <= 4'hf;
        else if (!wr_n) since_wr <= 4'h0;
        else if (since_wr != 4'hf) since_wr <= since_wr + 4'h1;
    end
    a_read_answer: assert property (
        $fell(rd_n) && !cs_n |-> ##[2:4] !ad_oe_n)
        else $error("read answer late");
    a_read_release: assert property (
        $rose(rd_n) |-> ##[2:4] ad_oe_n)
        else $error("bus not released after read");
    a_idle_no_drive: assert property (
        rd_n [*5] |-> ad_oe_n)
        else $error("bus driven without read");
    a_drive_needs_cs: assert property (
        !ad_oe_n |-> !$past(cs_n, 3))
        else $error("bus driven while deselected");
    a_strobe_single: assert property (
        line_bit_strobe |=> !line_bit_strobe)
        else $error("bit strobe longer than a cycle");
    a_strobe_follows: assert property (
        $rose(rclk) && !common_control[7] |-> ##[1:6] line_bit_strobe)
        else $error("line clock edge not taken");
    a_mark_holds: assert property (
        $changed(line_mark) |-> line_bit_strobe || $past(line_bit_strobe))
        else $error("line bit changed between strobes");
    a_ctrl_by_write: assert property (
        $changed(common_control) |-> since_wr >= 4'h1 && since_wr <= 4'h8)
        else $error("control changed without a write");
endmodule

bind e1_receive_alarm_status e1_rx_alarm_checker e1_rx_alarm_checker_inst (
    .mclk(mclk), .nrst(nrst), .rclk(rclk), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .ad_oe_n(ad_oe_n), .line_bit_strobe(line_bit_strobe),
    .line_mark(line_mark), .common_control(common_control));

// ===== tb/test_e1_receive_alarm_status.sv
// self-checking bench for the e1 receive alarm and status block
`timescale 1ns/1ps
`include "e1_rx_alarm_regs.svh"
module test_e1_receive_alarm_status;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        cs_n = 1'b1;
    logic        rd_n = 1'b1;
    logic        wr_n = 1'b1;
    logic        ale = 1'b0;
    logic        mark_in = 1'b0;
    logic [7:0]  ad_in = 8'h00;
    logic [7:0]  ad_out, ctrl, cc, q;
    logic        ad_oe_n, irq_n, strobe, rclk, rail_p, rail_n;
    logic [31:0] rv;
    int          bits = 0;
    int          n;
    int          n_fail = 0;
    int          check_count = 0;
    int          seed = 32'hd8f7;
    e1_rx_alarm_pkg::sync_status_type sync = 12'h800;
    e1_rx_alarm_pkg::line_pos_type    pos;
    e1_receive_alarm_status e1_receive_alarm_status_inst (
        .mclk(mclk), .nrst(nrst), .rclk(rclk),
        .rx_positive_rail(rail_p), .rx_negative_rail(rail_n),
        .tclk(rclk), .tx_positive_rail(rail_p), .tx_negative_rail(rail_n),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .ad_in(ad_in),
        .ad_out(ad_out), .ad_oe_n(ad_oe_n), .pos(pos), .sync(sync),
        .line_bit_strobe(strobe), .line_mark(),
        .common_control(ctrl), .first_irq_out_n(irq_n));
    e1_line_source e1_line_source_inst (.mclk(mclk), .nrst(nrst),
        .mark_in(mark_in), .rclk(rclk), .rail_p(rail_p), .rail_n(rail_n));
    always #25 mclk = ~mclk;
    // synchronizer position: bit, timeslot, frame counted from the strobe
    always @(posedge mclk) if (strobe) bits <= #1 bits + 1;
    assign pos = {bits[7:0], bits[11:8]};
    task summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task addr(input logic [7:0] a);
        ad_in = a;
        ale = 1'b1;
        cyc(3);
        ale = 1'b0;
        cyc(3);
        cs_n = 1'b0;
        cyc(1);
    endtask
    task bus_wr(input logic [7:0] a, input logic [7:0] d);
        addr(a);
        ad_in = d;
        wr_n = 1'b0;
        cyc(3);
        wr_n = 1'b1;
        cyc(4);
        cs_n = 1'b1;
        cyc(1);
    endtask
    // read held until the output enable answers, bounded
    task bus_rd(input logic [7:0] a, output logic [7:0] d);
        addr(a);
        rd_n = 1'b0;
        for (int i = 0; i < 8 && ad_oe_n !== 1'b0; i++) cyc(1);
        if (ad_oe_n !== 1'b0) begin
            n_fail++;
            summarize();
        end
        d = ad_out;
        rd_n = 1'b1;
        cyc(4);
        cs_n = 1'b1;
        cyc(1);
    endtask
    // mask write, read, then write back the read value under the mask
    task poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
        bus_wr(a, m);
        bus_rd(a, d);
        bus_wr(a, d & m);
    endtask
    task pulse(input logic [11:0] m);
        sync = sync | m;
        cyc(1);
        sync = sync & ~m;
        cyc(1);
    endtask
    task wait_bits(input int k);
        for (int i = 0; i < 60000 && bits < k; i++) @(posedge mclk);
        if (bits < k) begin
            n_fail++;
            summarize();
        end
        #1;
    endtask
    function logic [7:0] synchronizer_state(input int k, input logic [2:0] s);
        logic [5:0] c;
        c = k[5:0];
        return {c[5:2], c[0], s};
    endfunction
    initial begin
        repeat (16) @(posedge mclk);
        #1 nrst = 1'b1;
        cyc(3);
        chk({6'h00, ad_oe_n, irq_n}, 8'h03);
        // random receive modes and loopback, crc on
        rv = $random(seed);
        cc = {rv[7:1], 1'b1};
        bus_wr(`ADDR_COMMON_CTRL, cc);
        bus_rd(`ADDR_COMMON_CTRL, q);
        chk(q, cc);
        chk(ctrl, cc);
        // a frame error run broken by a good word and a lone signaling error fall short
        for (int i = 0; i < 5; i++) pulse(i == 2 ? 12'h020 : 12'h030);
        pulse(12'h00c);
        poll(`ADDR_RX_INFO, 8'h03, q);
        chk(q, 8'h00);
        pulse(12'h030);
        pulse(12'h00c);
        pulse(12'h002);
        pulse(12'h001);
        poll(`ADDR_RX_INFO, 8'hff, q);
        chk(q & 8'h1b, 8'h1b);
        poll(`ADDR_ALARM_STATUS, 8'h10, q);
        chk(q, 8'h10);
        poll(`ADDR_RX_INFO, 8'hff, q);
        chk(q & 8'h1b, 8'h00);
        // search counter with a forced wrap, then both ways of clearing
        for (int k = 0; k < 3; k++) begin
            rv = $random(seed);
            n = (k == 0) ? 65 : rv[15:8] % 70;
            sync[10:8] = rv[2:0];
            repeat (n) pulse(12'h040);
            bus_rd(`ADDR_SYNC_STATE, q);
            chk(q, synchronizer_state(n, rv[2:0]));
            pulse(12'h080);
            bus_rd(`ADDR_SYNC_STATE, q);
            chk(q, synchronizer_state(0, rv[2:0]));
        end
        repeat (5) pulse(12'h040);
        bus_wr(`ADDR_COMMON_CTRL, cc & 8'hfe);
        bus_rd(`ADDR_SYNC_STATE, q);
        chk(q, synchronizer_state(0, rv[2:0]));
        // sync loss masked, then unmasked, persisting, then gone
        bus_wr(`ADDR_IRQ_MASK, 8'h00);
        sync.in_sync = 1'b0;
        cyc(4);
        chk({7'h00, irq_n}, 8'h01);
        bus_wr(`ADDR_IRQ_MASK, 8'h01);
        cyc(2);
        chk({7'h00, irq_n}, 8'h00);
        poll(`ADDR_ALARM_STATUS, 8'h01, q);
        poll(`ADDR_ALARM_STATUS, 8'h01, q);
        chk(q, 8'h01);
        sync.in_sync = 1'b1;
        poll(`ADDR_ALARM_STATUS, 8'h01, q);
        poll(`ADDR_ALARM_STATUS, 8'h01, q);
        cyc(2);
        chk(q, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        // a multiframe of spaces, then marks across two frame 0s
        wait_bits(4100);
        poll(`ADDR_ALARM_STATUS, 8'h22, q);
        chk(q, 8'h22);
        mark_in = 1'b1;
        wait_bits(8400);
        poll(`ADDR_ALARM_STATUS, 8'hee, q);
        chk(q, 8'hee);
        poll(`ADDR_ALARM_STATUS, 8'hee, q);
        chk(q, 8'hc4);
        summarize();
    end
endmodule
